// file: cmp_defs.vh
/*
 * Register offsets, field positions, reset values and channel codes for
 * the dual comparator control block.
 * Assumes it is included by bare name into each design file that needs it.
 */
`ifndef CMP_DEFS_VH
`define CMP_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define OFS_SHARED_OUT 8'h6f
`define OFS_CTRL_A0 8'h70
`define OFS_CTRL_B0 8'h71
`define OFS_INV_SEL0 8'h72
`define OFS_NONINV_SEL0 8'h73
`define OFS_CTRL_A1 8'h74
`define OFS_CTRL_B1 8'h75
`define OFS_INV_SEL1 8'h76
`define OFS_NONINV_SEL1 8'h77
`define OFS_IRQ_FLAG 8'h78
`define OFS_IRQ_ENABLE 8'h7c
`define OFS_SYS_CTRL 8'h80

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define BIT_ENABLE 7
`define BIT_OUT 6
`define BIT_INVERT 4
`define BIT_HYST 1
`define BIT_SYNC 0
`define BIT_RISE_EN 1
`define BIT_FALL_EN 0
`define BIT_SLEEP 0
`define BIT_TMR_SYSCLK 1
`define BIT_GIE 2
`define BIT_ADC_TRIG0 3
`define BIT_ADC_TRIG1 4

// ----------------------------------------------------------------------
// Reset values and channel codes.
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_SEL 3'h0
`define CH_IN0 3'h0
`define CH_IN1 3'h1
`define CH_IN2 3'h2
`define CH_IN3 3'h3
`define CH_DAC 3'h5
`define CH_REF2 3'h6
`define CH_GND 3'h7

// ----------------------------------------------------------------------
// AXI4-Lite responses.
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: cmp_channel.v
/*
 * One comparator channel: enable gating, polarity, per-cycle latching,
 * edge detection and the timer-synchronised output path.
 * Assumes the raw analog result arrives already passed through two flops,
 * and that the timer clock level is likewise synchronised.
 */
`timescale 1ns/1ps
`include "cmp_defs.vh"

module cmp_channel (
	input wire ref_clk_i,
	input wire rst_i,
	input wire enable_i,
	input wire output_invert_i,
	input wire sync_enable_i,
	input wire sync_run_i,
	input wire raw_result_i,
	input wire timer_clk_fall_i,
	output reg out_q,
	output wire rise_o,
	output wire fall_o,
	output reg sync_out_q,
	output wire pin_out_o
);

	wire gated;
	wire polarised;
	reg prev_q;

	assign gated = enable_i & raw_result_i; // RULE_01 RULE_02 RULE_03
	assign polarised = gated ^ output_invert_i; // RULE_06 RULE_14

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			out_q <= 1'b0;
			prev_q <= 1'b0;
			sync_out_q <= 1'b0;
		end else begin
			out_q <= polarised; // RULE_05
			prev_q <= out_q; // RULE_23
			if (timer_clk_fall_i && sync_run_i) begin
				sync_out_q <= out_q; // RULE_07 RULE_08 RULE_09 RULE_17
			end
		end
	end

	assign rise_o = out_q & ~prev_q; // RULE_23
	assign fall_o = ~out_q & prev_q; // RULE_23
	// Unsynchronised path passes the polarised result without a register.
	assign pin_out_o = sync_enable_i ? sync_out_q : polarised; // RULE_05

endmodule // cmp_channel

// file: cmp_mux.v
/*
 * Input channel decoder for one comparator: one-hot select lines
 * for the noninverting and inverting analog multiplexers.
 * Assumes the analog switches close on a high select line.
 */
`timescale 1ns/1ps
`include "cmp_defs.vh"

module cmp_mux (
	input wire enable_i,
	input wire [2:0] noninv_channel_select_i,
	input wire [2:0] inv_channel_select_i,
	output reg [3:0] noninv_sel_o,
	output reg [5:0] inv_sel_o
);

	// Noninverting lines: in0, in1, dac, ref2 ; the ground code selects no line.
	always @* begin
		noninv_sel_o = 4'h0;
		if (enable_i) begin // RULE_02
			case (noninv_channel_select_i) // RULE_15 RULE_22
			`CH_IN0: noninv_sel_o = 4'h1;
			`CH_IN1: noninv_sel_o = 4'h2;
			`CH_DAC: noninv_sel_o = 4'h4;
			`CH_REF2: noninv_sel_o = 4'h8;
			default: noninv_sel_o = 4'h0;
			endcase
		end
	end

	// Inverting lines: in0..in3, ref2, ground.
	always @* begin
		inv_sel_o = 6'h00;
		if (enable_i) begin // RULE_02
			case (inv_channel_select_i) // RULE_15
			`CH_IN0: inv_sel_o = 6'h01;
			`CH_IN1: inv_sel_o = 6'h02;
			`CH_IN2: inv_sel_o = 6'h04;
			`CH_IN3: inv_sel_o = 6'h08;
			`CH_REF2: inv_sel_o = 6'h10;
			`CH_GND: inv_sel_o = 6'h20;
			default: inv_sel_o = 6'h00;
			endcase
		end
	end

endmodule // cmp_mux

// file: cmp_ctrl.v
/*
 * Dual analog comparator control with an AXI4-Lite register slave.
 * Holds the control registers, the interrupt flags, wake and ADC trigger,
 * and the analog-side select outputs.
 * Assumes the analog comparators and the timer clock are asynchronous
 * and are synchronised here by two flops before use.
 */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
// Notes on behaviour
// RULE_01: Raw result is high when noninverting input exceeds inverting input.
// RULE_02: Enable clear disconnects all input selects and forces output low; the output reads high here when invert is set.
// RULE_03: Enable set runs the comparator; clear disables it and its inputs.
// RULE_04: Each output reads in its control register and in a shared register.
// RULE_05: Internal output registered every cycle; pin path unregistered unless synced; pin_out_o adds one register on both paths.
// RULE_06: Invert bit 0 passes the result; 1 inverts it.
// RULE_07: With sync set, output captured on the timer clock falling edge.
// RULE_08: Sync capture uses the prescaled timer clock when a prescaler is used.
// RULE_09: Timer advances on rising edge; synced output changes only on falling.
// RULE_10: Hysteresis bit switches that comparator's input hysteresis on or off.
// RULE_11: Flag sets on rising edge with rise enable or falling with fall enable.
// RULE_12: Software enables comparator, edge enables, irq enable and global enable.
// RULE_13: Software clears the flag after each event before the next report.
// RULE_14: Toggling the invert bit makes an edge that can set the flag.
// RULE_15: Select fields route pins, references or ground to the two inputs.
// RULE_16: Comparator runs in sleep and its enabled interrupt wakes the device.
// RULE_17: Synced output freezes in sleep when the timer runs on system clock.
// RULE_18: Software routes output to a pin and clears its direction bit.
// RULE_19: Software sets analog select and direction bit on input pins.
// RULE_20: Shared register bit 0 mirrors comparator one, bit 1 comparator two.
// RULE_21: As ADC trigger source, each rising output edge requests a conversion.
// RULE_22: Noninverting code 000 in0, 001 in1, 101 DAC, 110 ref2, 111 ground; code 111 drives no select line.
// RULE_23: Edges found by comparing registered output with the previous cycle.
`timescale 1ns/1ps
`include "cmp_defs.vh"

module cmp_ctrl #(
	parameter N_CMP = 2
) (
	input wire ref_clk_i,
	input wire rst_i,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] raw_result_i,
	input wire timer_clk_i,
	output reg [1:0] cmp_enable_o,
	output reg [1:0] hysteresis_enable_o,
	output reg [7:0] noninv_sel_o,
	output reg [11:0] inv_sel_o,
	output reg [1:0] pin_out_o,
	output reg [1:0] timer_cmp_o,
	output reg irq_o,
	output reg wake_o,
	output reg adc_trigger_o
);

	// ------------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------------
	reg [1:0] en_q, inv_q, hys_q, sync_q, rise_en_q, fall_en_q;
	reg [2:0] pch0_q, pch1_q, nch0_q, nch1_q;
	reg [1:0] flag_q, irq_en_q;
	reg [4:0] sys_q;
	reg [1:0] raw_meta_q, raw_sync_q;
	reg tclk_meta_q, tclk_sync_q, tclk_prev_q;

	// ------------------------------------------------------------------
	// Input synchronisers and timer clock falling edge.
	// ------------------------------------------------------------------
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			raw_meta_q <= 2'h0;
			raw_sync_q <= 2'h0;
			tclk_meta_q <= 1'b0;
			tclk_sync_q <= 1'b0;
			tclk_prev_q <= 1'b0;
		end else begin
			raw_meta_q <= raw_result_i;
			raw_sync_q <= raw_meta_q;
			tclk_meta_q <= timer_clk_i;
			tclk_sync_q <= tclk_meta_q;
			tclk_prev_q <= tclk_sync_q;
		end
	end

	// The timer clock given here is already after its prescaler.
	wire tclk_fall = tclk_prev_q & ~tclk_sync_q; // RULE_08 RULE_09
	wire sleeping = sys_q[`BIT_SLEEP];
	// Timer on the system clock stops in sleep, so does the synced output.
	wire sync_run = ~(sleeping & sys_q[`BIT_TMR_SYSCLK]); // RULE_17

	// ------------------------------------------------------------------
	// Comparator channels.
	// ------------------------------------------------------------------
	wire [1:0] out_w, rise_w, fall_w, sync_out_w, pin_w;
	wire [3:0] nsel0_w, nsel1_w;
	wire [5:0] isel0_w, isel1_w;

	cmp_channel u_ch0 (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.enable_i(en_q[0]),
		.output_invert_i(inv_q[0]),
		.sync_enable_i(sync_q[0]),
		.sync_run_i(sync_run),
		.raw_result_i(raw_sync_q[0]),
		.timer_clk_fall_i(tclk_fall),
		.out_q(out_w[0]),
		.rise_o(rise_w[0]),
		.fall_o(fall_w[0]),
		.sync_out_q(sync_out_w[0]),
		.pin_out_o(pin_w[0])
	);

	cmp_channel u_ch1 (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.enable_i(en_q[1]),
		.output_invert_i(inv_q[1]),
		.sync_enable_i(sync_q[1]),
		.sync_run_i(sync_run),
		.raw_result_i(raw_sync_q[1]),
		.timer_clk_fall_i(tclk_fall),
		.out_q(out_w[1]),
		.rise_o(rise_w[1]),
		.fall_o(fall_w[1]),
		.sync_out_q(sync_out_w[1]),
		.pin_out_o(pin_w[1])
	);

	cmp_mux u_mux0 (
		.enable_i(en_q[0]),
		.noninv_channel_select_i(pch0_q),
		.inv_channel_select_i(nch0_q),
		.noninv_sel_o(nsel0_w),
		.inv_sel_o(isel0_w)
	);

	cmp_mux u_mux1 (
		.enable_i(en_q[1]),
		.noninv_channel_select_i(pch1_q),
		.inv_channel_select_i(nch1_q),
		.noninv_sel_o(nsel1_w),
		.inv_sel_o(isel1_w)
	);

	// ------------------------------------------------------------------
	// Edge events.
	// ------------------------------------------------------------------
	wire [1:0] event_w = (rise_w & rise_en_q) | (fall_w & fall_en_q); // RULE_11
	wire [1:0] adc_sel = {sys_q[`BIT_ADC_TRIG1], sys_q[`BIT_ADC_TRIG0]};

	// ------------------------------------------------------------------
	// AXI4-Lite write path.
	// ------------------------------------------------------------------
	reg aw_got_q;
	reg w_got_q;
	reg [7:0] aw_addr_q;
	reg [7:0] w_byte_q;
	reg w_strb_q;
	wire do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire [7:0] wb = w_byte_q;
	reg wr_hit;

	// Shared output up to the flag register is one contiguous mapped run.
	always @* begin
		wr_hit = 1'b0;
		if (aw_addr_q >= `OFS_SHARED_OUT && aw_addr_q <= `OFS_IRQ_FLAG) begin
			wr_hit = 1'b1;
		end else if (aw_addr_q == `OFS_IRQ_ENABLE) begin
			wr_hit = 1'b1;
		end else if (aw_addr_q == `OFS_SYS_CTRL) begin
			wr_hit = 1'b1;
		end
	end

	wire wr_en = do_write & w_strb_q;
	// Flags clear when software writes zero to a set bit.
	wire [1:0] flag_clr = (wr_en && aw_addr_q == `OFS_IRQ_FLAG) ?
		~wb[1:0] : 2'h0;

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= `RST_BYTE;
			w_byte_q <= `RST_BYTE;
			w_strb_q <= 1'b0;
			en_q <= 2'h0;
			inv_q <= 2'h0;
			hys_q <= 2'h0;
			sync_q <= 2'h0;
			rise_en_q <= 2'h0;
			fall_en_q <= 2'h0;
			pch0_q <= `RST_SEL;
			pch1_q <= `RST_SEL;
			nch0_q <= `RST_SEL;
			nch1_q <= `RST_SEL;
			flag_q <= 2'h0;
			irq_en_q <= 2'h0;
			sys_q <= 5'h00;
		end else begin
			s_axi_awready <= ~aw_got_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_got_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				w_byte_q <= s_axi_wdata[7:0];
				w_strb_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_en) begin
				if (aw_addr_q == `OFS_CTRL_A0) begin
					en_q[0] <= wb[`BIT_ENABLE]; // RULE_03
					inv_q[0] <= wb[`BIT_INVERT]; // RULE_06
					hys_q[0] <= wb[`BIT_HYST]; // RULE_10
					sync_q[0] <= wb[`BIT_SYNC]; // RULE_07
				end else if (aw_addr_q == `OFS_CTRL_B0) begin
					rise_en_q[0] <= wb[`BIT_RISE_EN];
					fall_en_q[0] <= wb[`BIT_FALL_EN];
				end else if (aw_addr_q == `OFS_INV_SEL0) begin
					nch0_q <= wb[2:0];
				end else if (aw_addr_q == `OFS_NONINV_SEL0) begin
					pch0_q <= wb[2:0];
				end else if (aw_addr_q == `OFS_CTRL_A1) begin
					en_q[1] <= wb[`BIT_ENABLE]; // RULE_03
					inv_q[1] <= wb[`BIT_INVERT]; // RULE_06
					hys_q[1] <= wb[`BIT_HYST]; // RULE_10
					sync_q[1] <= wb[`BIT_SYNC]; // RULE_07
				end else if (aw_addr_q == `OFS_CTRL_B1) begin
					rise_en_q[1] <= wb[`BIT_RISE_EN];
					fall_en_q[1] <= wb[`BIT_FALL_EN];
				end else if (aw_addr_q == `OFS_INV_SEL1) begin
					nch1_q <= wb[2:0];
				end else if (aw_addr_q == `OFS_NONINV_SEL1) begin
					pch1_q <= wb[2:0];
				end else if (aw_addr_q == `OFS_IRQ_ENABLE) begin
					irq_en_q <= wb[1:0];
				end else if (aw_addr_q == `OFS_SYS_CTRL) begin
					sys_q <= wb[4:0];
				end
			end
			// A new event wins over a clear in the same cycle.
			flag_q <= (flag_q & ~flag_clr) | event_w; // RULE_11 RULE_13
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path.
	// ------------------------------------------------------------------
	reg [7:0] rd_byte;
	reg rd_hit;
	wire [7:0] ctrl_a0 = {en_q[0], out_w[0], 1'b0, inv_q[0], 2'h0,
		hys_q[0], sync_q[0]};
	wire [7:0] ctrl_a1 = {en_q[1], out_w[1], 1'b0, inv_q[1], 2'h0,
		hys_q[1], sync_q[1]};

	always @* begin
		rd_byte = `RST_BYTE;
		rd_hit = 1'b1;
		if (s_axi_araddr == `OFS_SHARED_OUT) begin
			rd_byte = {6'h00, out_w[1], out_w[0]}; // RULE_04 RULE_20
		end else if (s_axi_araddr == `OFS_CTRL_A0) begin
			rd_byte = ctrl_a0; // RULE_04
		end else if (s_axi_araddr == `OFS_CTRL_B0) begin
			rd_byte = {6'h00, rise_en_q[0], fall_en_q[0]};
		end else if (s_axi_araddr == `OFS_INV_SEL0) begin
			rd_byte = {5'h00, nch0_q};
		end else if (s_axi_araddr == `OFS_NONINV_SEL0) begin
			rd_byte = {5'h00, pch0_q};
		end else if (s_axi_araddr == `OFS_CTRL_A1) begin
			rd_byte = ctrl_a1; // RULE_04
		end else if (s_axi_araddr == `OFS_CTRL_B1) begin
			rd_byte = {6'h00, rise_en_q[1], fall_en_q[1]};
		end else if (s_axi_araddr == `OFS_INV_SEL1) begin
			rd_byte = {5'h00, nch1_q};
		end else if (s_axi_araddr == `OFS_NONINV_SEL1) begin
			rd_byte = {5'h00, pch1_q};
		end else if (s_axi_araddr == `OFS_IRQ_FLAG) begin
			rd_byte = {6'h00, flag_q};
		end else if (s_axi_araddr == `OFS_IRQ_ENABLE) begin
			rd_byte = {6'h00, irq_en_q};
		end else if (s_axi_araddr == `OFS_SYS_CTRL) begin
			rd_byte = {3'h0, sys_q};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Registered outputs.
	// ------------------------------------------------------------------
	wire [1:0] pend = flag_q & irq_en_q;

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			cmp_enable_o <= 2'h0;
			hysteresis_enable_o <= 2'h0;
			noninv_sel_o <= 8'h00;
			inv_sel_o <= 12'h000;
			pin_out_o <= 2'h0;
			timer_cmp_o <= 2'h0;
			irq_o <= 1'b0;
			wake_o <= 1'b0;
			adc_trigger_o <= 1'b0;
		end else begin
			cmp_enable_o <= en_q; // RULE_03
			hysteresis_enable_o <= hys_q & en_q; // RULE_10
			noninv_sel_o <= {nsel1_w, nsel0_w}; // RULE_15 RULE_22
			inv_sel_o <= {isel1_w, isel0_w}; // RULE_15
			pin_out_o <= pin_w; // RULE_05
			timer_cmp_o <= pin_w; // RULE_07
			irq_o <= (|pend) & sys_q[`BIT_GIE];
			wake_o <= (|pend) & sleeping; // RULE_16
			adc_trigger_o <= |(rise_w & adc_sel); // RULE_21
		end
	end

endmodule // cmp_ctrl

// file: cmp_ctrl_assertions.sv
/* Concurrent checks on the ports of the comparator control block.
 * Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps

module cmp_ctrl_assertions (
	input wire ref_clk_i,
	input wire rst_i,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] cmp_enable_o,
	input wire [1:0] hysteresis_enable_o,
	input wire [7:0] noninv_sel_o,
	input wire [11:0] inv_sel_o,
	input wire [1:0] pin_out_o,
	input wire [1:0] timer_cmp_o,
	input wire irq_o,
	input wire wake_o,
	input wire adc_trigger_o
);
	// Cycles left in which a register write may still reach the outputs.
	reg [2:0] wr_cnt_q;

	always @(posedge ref_clk_i) begin
		if (rst_i)
			wr_cnt_q <= 3'h0;
		else if (s_axi_wvalid && s_axi_wready)
			wr_cnt_q <= 3'h5;
		else if (wr_cnt_q != 3'h0)
			wr_cnt_q <= wr_cnt_q - 3'h1;
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	dis_sel_a: assert property (
		!cmp_enable_o[0] && !$past(cmp_enable_o[0]) |->
		noninv_sel_o[3:0] == 4'h0 && inv_sel_o[5:0] == 6'h00)
		else $error("input selected while comparator off");
	en_write_a: assert property (
		$changed(cmp_enable_o) |-> wr_cnt_q != 3'h0)
		else $error("enable changed without a register write");
	hys_gate_a: assert property (
		(hysteresis_enable_o & ~cmp_enable_o & ~$past(cmp_enable_o)) == 2'h0)
		else $error("hysteresis on while comparator off");
	noninv_hot_a: assert property (
		$onehot0(noninv_sel_o[3:0]) && $onehot0(noninv_sel_o[7:4]))
		else $error("several noninverting inputs selected");
	inv_hot_a: assert property (
		$onehot0(inv_sel_o[5:0]) && $onehot0(inv_sel_o[11:6]))
		else $error("several inverting inputs selected");
	adc_pulse_a: assert property (
		adc_trigger_o |=> !adc_trigger_o)
		else $error("conversion request longer than one cycle");
	pin_timer_a: assert property (
		pin_out_o == timer_cmp_o)
		else $error("pin and timer copies of the output differ");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed before it was taken");

	irq_c: cover property ($rose(irq_o));
	adc_c: cover property (adc_trigger_o);
	wake_c: cover property (wake_o);
	pin_c: cover property ($changed(pin_out_o));
endmodule // cmp_ctrl_assertions

bind cmp_ctrl cmp_ctrl_assertions u_cmp_ctrl_assertions (.*);

// file: cmp_analog_model.sv
/* Behavioural model of the analog side: input pins, references, DAC.
 * Assumes the bench sets the levels in lv; ground is always zero. */
`timescale 1ns/1ps

module cmp_analog_model (
	input wire ref_clk_i,
	input wire [1:0] cmp_enable_i,
	input wire [7:0] noninv_sel_i,
	input wire [11:0] inv_sel_i,
	output logic [1:0] raw_o
);
	// Levels per comparator: in0, in1, in2, in3, dac, ref2.
	int lv [2][6];
	int vp;
	int vn;

	initial raw_o = 2'h0;

	always @(posedge ref_clk_i) begin
		for (int c = 0; c < 2; c++) begin
			vp = 0;
			vn = 0;
			for (int k = 0; k < 4; k++) begin
				if (noninv_sel_i[4 * c + k])
					vp += lv[c][k < 2 ? k : k + 2];
				if (inv_sel_i[6 * c + k])
					vn += lv[c][k];
			end
			if (inv_sel_i[6 * c + 4])
				vn += lv[c][5];
			// A comparator that is off gives no settled level at all.
			if (cmp_enable_i[c])
				raw_o[c] <= vp > vn;
			else
				raw_o[c] <= ~raw_o[c];
		end
	end
endmodule // cmp_analog_model

// file: test_analog_comparator_control.sv
/* Self-checking bench for the dual comparator control block.
 * Assumes the analog model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`include "cmp_defs.vh"

module test_analog_comparator_control;
	logic ref_clk_i, rst_i, timer_clk_i;
	logic [7:0] s_axi_awaddr, s_axi_araddr, noninv_sel_o;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, irq_o, wake_o, adc_trigger_o;
	logic [1:0] s_axi_bresp, s_axi_rresp, raw_result_i, cmp_enable_o;
	logic [1:0] hysteresis_enable_o, pin_out_o, timer_cmp_o, er;
	logic [11:0] inv_sel_o;
	logic [3:0] ps [8] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 4'h4, 4'h8, 4'h0};
	logic [5:0] ns [8] = '{6'h01, 6'h02, 6'h04, 6'h08,
		6'h00, 6'h00, 6'h10, 6'h20};
	int error_cnt = 0;
	int total_checks = 0;
	int adc_cnt = 0;
	int o, output_invert, hi, ex;

	cmp_ctrl u_cmp_ctrl (.*);
	cmp_analog_model u_cmp_analog_model (
		.ref_clk_i(ref_clk_i),
		.cmp_enable_i(cmp_enable_o),
		.noninv_sel_i(noninv_sel_o),
		.inv_sel_i(inv_sel_o),
		.raw_o(raw_result_i)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		if (adc_trigger_o === 1'b1)
			adc_cnt++;
	end

	// ----------
	// Bus cycles and comparisons
	// ----------
	task automatic end_of_test;
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic lim(int n);
		if (n >= 40) begin
			error_cnt++;
			$display("mismatch bus_answer expected response seen none");
			end_of_test;
		end
	endtask

	task automatic wr(int a, int d, logic [1:0] r = `RESP_OKAY);
		int n;
		n = 0;
		s_axi_awaddr <= a[7:0];
		s_axi_wdata <= {24'h0, d[7:0]};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 40);
		lim(n);
		chk("bresp", r, s_axi_bresp);
		s_axi_bready <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task automatic rc(int a, int e, logic [1:0] r = `RESP_OKAY);
		int n;
		n = 0;
		s_axi_araddr <= a[7:0];
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			else if (!s_axi_arvalid)
				s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
		lim(n);
		chk("rdata", e, s_axi_rdata);
		chk("rresp", r, s_axi_rresp);
		s_axi_rready <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// Waits out the analog response time and the input synchronisers.
	task automatic settle;
		repeat (10) @(posedge ref_clk_i);
	endtask

	task automatic lvl(int c, int p, int n);
		u_cmp_analog_model.lv[c][0] <= p;
		u_cmp_analog_model.lv[c][1] <= n;
	endtask

	task automatic sync_step(int p, logic t, int e);
		lvl(0, p, 400);
		settle;
		timer_clk_i <= t;
		settle;
		chk("pin_sync", e, pin_out_o[0]);
		chk("timer_cmp", e, timer_cmp_o[0]);
	endtask

	// ----------
	// Main sequence
	// ----------
	initial begin
		rst_i = 1'b1;
		timer_clk_i = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		for (int a = 8'h6f; a <= 8'h80; a++) begin
			er = (a > 8'h78 && a != 8'h7c && a != 8'h80) ? 2'h2 : 2'h0;
			rc(a, 0, er);
		end
		wr(8'h7e, 8'hff, `RESP_SLVERR);
		s_axi_wstrb <= 4'he;
		wr(`OFS_CTRL_B1, 3);
		s_axi_wstrb <= 4'hf;
		rc(`OFS_CTRL_B1, 0);
		for (int c = 0; c < 2; c++) begin
			wr(`OFS_CTRL_A0 + 4 * c, 8'h80);
			for (int k = 0; k < 8; k++) begin
				wr(`OFS_NONINV_SEL0 + 4 * c, k);
				wr(`OFS_INV_SEL0 + 4 * c, k);
				rc(`OFS_INV_SEL0 + 4 * c, k);
				chk("noninv_sel", ps[k], noninv_sel_o[4 * c +: 4]);
				chk("inv_sel", ns[k], inv_sel_o[6 * c +: 6]);
			end
			wr(`OFS_NONINV_SEL0 + 4 * c, 0);
			wr(`OFS_INV_SEL0 + 4 * c, 1);
			for (int m = 0; m < 4; m++) begin
				output_invert = m / 2;
				hi = m % 2;
				o = hi ^ output_invert;
				lvl(c, hi ? 600 : 200, 400);
				wr(`OFS_CTRL_A0 + 4 * c, 8'h82 | output_invert << 4);
				settle;
				rc(`OFS_CTRL_A0 + 4 * c, 8'h82 | o << 6 | output_invert << 4);
				rc(`OFS_SHARED_OUT, o << c);
				chk("pin_out", o, pin_out_o[c]);
				chk("hysteresis", 1, hysteresis_enable_o[c]);
				chk("enable", 1, cmp_enable_o[c]);
			end
			wr(`OFS_CTRL_A0 + 4 * c, 0);
			settle;
			rc(`OFS_CTRL_A0 + 4 * c, 0);
			chk("noninv_off", 0, noninv_sel_o[4 * c +: 4]);
			chk("enable_off", 0, cmp_enable_o[c]);
		end
		lvl(0, 200, 400);
		wr(`OFS_CTRL_A0, 8'h80);
		wr(`OFS_IRQ_ENABLE, 1);
		wr(`OFS_SYS_CTRL, 8'h0c);
		settle;
		adc_cnt = 0;
		for (int m = 0; m < 4; m++) begin
			ex = (m == 0 || m == 3);
			wr(`OFS_CTRL_B0, m < 2 ? 2 : 1);
			lvl(0, m % 2 ? 200 : 600, 400);
			settle;
			rc(`OFS_IRQ_FLAG, ex);
			chk("irq", ex, irq_o);
			wr(`OFS_IRQ_FLAG, 0);
			rc(`OFS_IRQ_FLAG, 0);
		end
		chk("adc_requests", 2, adc_cnt);
		wr(`OFS_CTRL_A0, 8'h00);
		wr(`OFS_CTRL_B0, 2);
		wr(`OFS_CTRL_A0, 8'h10);
		settle;
		rc(`OFS_CTRL_A0, 8'h50);
		rc(`OFS_IRQ_FLAG, 1);
		wr(`OFS_CTRL_A0, 8'h81);
		sync_step(600, 1'b0, 1);
		sync_step(200, 1'b1, 1);
		sync_step(200, 1'b0, 0);
		wr(`OFS_SYS_CTRL, 8'h07);
		sync_step(600, 1'b1, 0);
		sync_step(600, 1'b0, 0);
		rc(`OFS_CTRL_A0, 8'hc1);
		chk("wake", 1, wake_o);
		end_of_test;
	end
endmodule // test_analog_comparator_control
